/* File: hw/sfs_consts.svh */
// constants for the source fault supervisor: timing, power steps, register map
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define CLK_MHZ 125
`define MS2CYC(ms) ((ms) * `CLK_MHZ * 1000)
`define US2CYC(us) ((us) * `CLK_MHZ)
`define T_EN_MS 100
`define T_DSW_MS 900
`define T_VBUS_BLEED_PIN_SHI_MS 7
`define T_VBUS_BLEED_PIN_SLO_MS 19
`define T_VBUS_BLEED_PIN_BHI_MS 55
`define T_VBUS_BLEED_PIN_BLO_MS 221
`define T_BAT_DEB_MS 2
`define T_RESTART_MS 2000
`define T_OCP_DEB_US 1000
`define T_CCOVP_DEB_US 1000
`define T_VCONN_DEB_US 1000
`define PCT_100 7'h64
`define PCT_75 7'h4B
`define PCT_50 7'h32
`define PCT_25 7'h19
`define SCALE_DEF 7'h4B
`define SCALE_MIN 7'h19
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define CTRL_TRIM5A 0
`define CTRL_RST 1'h0
`endif

/* File: hw/sfs_pkg.sv */
// types shared by the source fault supervisor
package sfs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_EN, ST_ON, ST_PROT, ST_RESTART
    } sup_state_t;
    // asynchronous comparator results
    typedef struct packed {
        logic ovp;
        logic uvp;
        logic ocp;
        logic ext_ot;
        logic int_ot;
        logic dline_ovp;
        logic cc1_ovp;
        logic cc2_ovp;
        logic vconn_oc;
        logic bat_float_low;
        logic bat_div_low;
        logic ntc_warn;
        logic light_load;
        logic vbus_present;
    } cmp_flags_t;
    // voltage transition request from the policy layer
    typedef struct packed {
        logic req;
        logic small_step;
        logic above_13v;
    } vtrans_t;
endpackage

/* File: hw/source_fault_supervisor.sv */
// fault supervision and power sequencing for a usb-c source controller
//
// Behaviour
// - bleed path only while output current is below the light-load limit
// - transition bleed time 7/19/55/221 ms by step size and level
// - detach, protection or hard reset bleeds vbus for 221 ms
// - any fault disables converter and enables bleed
// - pull-up currents off while in protection
// - faults clear: bleed again, run restart timer, then pull-ups on
// - converter enable high 100 ms after attach, low while unattached
// - converter enable low on detach, reset or protection
// - charging downstream port mode presented by default
// - data switch high 900 ms after attach until unplug
// - data switch low on detach, reset or protection
// - battery low from float compare or divider compare per sense mode
// - battery low must persist 2 ms before renegotiation
// - battery low advertises 75 percent, recovery restores and renegotiates
// - thermal warning scales power like battery low
// - thermistor shutdown enters protection and disconnects sink
// - advertised power: full, times 75 percent, or 25 percent if both
// - select pins 11/10/01/00 give 100/75/50/25 percent
// - select pin change recomputes power and sends new capabilities
// - cable supply only when five amp trim is set
// - cable supply overcurrent: supply off, limit 3 A, status bit
// - config line overvoltage past debounce raises protection
// - converter enabled only after vbus has been discharged
// - output overcurrent armed only on fixed contracts and while in protection, debounced
//
// Local design decisions: the register addresses and the plain strobed port.
`include "sfs_consts.svh"
module source_fault_supervisor #(
    parameter int unsigned T_EN = `MS2CYC(`T_EN_MS),
    parameter int unsigned T_DSW = `MS2CYC(`T_DSW_MS),
    parameter int unsigned T_SHI = `MS2CYC(`T_VBUS_BLEED_PIN_SHI_MS),
    parameter int unsigned T_SLO = `MS2CYC(`T_VBUS_BLEED_PIN_SLO_MS),
    parameter int unsigned T_BHI = `MS2CYC(`T_VBUS_BLEED_PIN_BHI_MS),
    parameter int unsigned T_BLO = `MS2CYC(`T_VBUS_BLEED_PIN_BLO_MS),
    parameter int unsigned T_BAT = `MS2CYC(`T_BAT_DEB_MS),
    parameter int unsigned T_RST = `MS2CYC(`T_RESTART_MS),
    parameter int unsigned T_OCP = `US2CYC(`T_OCP_DEB_US),
    parameter int unsigned T_CCO = `US2CYC(`T_CCOVP_DEB_US),
    parameter int unsigned T_VCO = `US2CYC(`T_VCONN_DEB_US)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // analog comparator flags
    input wire sfs_pkg::cmp_flags_t cmp_flags,
    input wire logic battery_sense_float,
    // connection and policy layer
    input wire logic cc_attached,
    input wire logic hard_reset,
    input wire sfs_pkg::vtrans_t vtrans,
    input wire logic fixed_contract,
    input wire logic cable_discover_req,
    // power select pins
    input wire logic power_select_msb,
    input wire logic power_select_lsb,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // converter, switch and connector controls
    output logic converter_enable_out,
    output logic data_switch_ctrl,
    output logic vbus_bleed_pin,
    output logic source_pullup_current,
    output logic vconn_enable,
    output logic cdp_mode,
    // power advertisement to the policy layer
    output logic [6:0] advertised_power,
    output logic caps_update,
    output logic cable_limit,
    output logic protection_active
);
    localparam int NFL = $bits(sfs_pkg::cmp_flags_t);
    localparam int unsigned DEB_LIM [4] = '{T_OCP, T_CCO, T_VCO, T_BAT};

    logic [NFL-1:0] sync1_ff;
    logic [NFL-1:0] sync2_ff;
    sfs_pkg::cmp_flags_t fl;
    logic [3:0] deb_in;
    logic [3:0] deb_out;
    sfs_pkg::sup_state_t state_ff;
    sfs_pkg::sup_state_t nxt_state;
    logic [31:0] att_cnt_ff;
    logic [31:0] rst_cnt_ff;
    logic [31:0] vbus_bleed_pin_cnt_ff;
    logic [31:0] nxt_vbus_bleed_pin;
    logic [31:0] trans_len;
    logic fault;
    logic detach;
    logic en_ff;
    logic dsw_ff;
    logic bleed_ff;
    logic trim5a_ff;
    logic cable_lim_ff;
    logic bat_raw;
    logic bat_low;
    logic [1:0] sel;
    logic [1:0] sel_ff;
    logic [6:0] cfg_pct;
    logic [6:0] scale_pct;
    logic [13:0] adv_prod;
    logic [13:0] adv_div;
    logic [6:0] adv_ff;
    logic caps_ff;
    logic [31:0] rdata_ff;
    logic ocp_armed;

    // two-flop synchronisers on every comparator flag
    generate
        for (genvar i = 0; i < NFL; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    sync1_ff[i] <= 1'b0;
                    sync2_ff[i] <= 1'b0;
                end else begin
                    sync1_ff[i] <= cmp_flags[i];
                    sync2_ff[i] <= sync1_ff[i];
                end
            end
        end
    endgenerate
    assign fl = sfs_pkg::cmp_flags_t'(sync2_ff);

    // debounce inputs: ocp, config_line_overvoltage_fault, cable supply oc, battery low
    // held armed in protection, else a lasting overcurrent would drop out at once
    assign ocp_armed = ((state_ff == sfs_pkg::ST_ON) && fixed_contract)
        || (state_ff == sfs_pkg::ST_PROT);
    assign bat_raw = battery_sense_float ? fl.bat_float_low : fl.bat_div_low;
    assign deb_in[0] = fl.ocp && ocp_armed;
    assign deb_in[1] = fl.cc1_ovp || fl.cc2_ovp;
    assign deb_in[2] = fl.vconn_oc && vconn_enable;
    assign deb_in[3] = bat_raw;

    // one saturating counter per debounced condition
    generate
        for (genvar d = 0; d < 4; d++) begin : g_deb
            logic [31:0] cnt_ff;
            always_ff @(posedge clk) begin
                if (!rst_b || !deb_in[d]) begin
                    cnt_ff <= 32'h0;
                end else if (cnt_ff != DEB_LIM[d]) begin
                    cnt_ff <= cnt_ff + 32'h1;
                end
            end
            assign deb_out[d] = deb_in[d] && (cnt_ff == DEB_LIM[d]);
        end
    endgenerate
    assign bat_low = deb_out[3];

    // any protection cause; thermistor shutdown is ext_ot
    assign fault = fl.ovp || fl.uvp || deb_out[0] || fl.ext_ot
        || fl.int_ot || fl.dline_ovp || deb_out[1];
    assign detach = !cc_attached && ((state_ff == sfs_pkg::ST_ON)
        || (state_ff == sfs_pkg::ST_WAIT_EN));

    // supervisor state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sfs_pkg::ST_IDLE: begin
                if (fault) begin
                    nxt_state = sfs_pkg::ST_PROT;
                end else if (cc_attached) begin
                    nxt_state = sfs_pkg::ST_WAIT_EN;
                end
            end
            sfs_pkg::ST_WAIT_EN: begin
                if (fault) begin
                    nxt_state = sfs_pkg::ST_PROT;
                end else if (!cc_attached) begin
                    nxt_state = sfs_pkg::ST_IDLE;
                end else if (att_cnt_ff >= T_EN && !fl.vbus_present) begin
                    nxt_state = sfs_pkg::ST_ON;
                end
            end
            sfs_pkg::ST_ON: begin
                if (fault) begin
                    nxt_state = sfs_pkg::ST_PROT;
                end else if (!cc_attached) begin
                    nxt_state = sfs_pkg::ST_IDLE;
                end
            end
            sfs_pkg::ST_PROT: begin
                if (!fault) begin
                    nxt_state = sfs_pkg::ST_RESTART;
                end
            end
            sfs_pkg::ST_RESTART: begin
                if (fault) begin
                    nxt_state = sfs_pkg::ST_PROT;
                end else if (rst_cnt_ff >= T_RST) begin
                    nxt_state = sfs_pkg::ST_IDLE;
                end
            end
            default: nxt_state = sfs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= sfs_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // attach timer runs from debounce completion while attached
    always_ff @(posedge clk) begin
        if (!rst_b || (nxt_state != sfs_pkg::ST_WAIT_EN && nxt_state != sfs_pkg::ST_ON)) begin
            att_cnt_ff <= 32'h0;
        end else if (att_cnt_ff < T_DSW) begin
            att_cnt_ff <= att_cnt_ff + 32'h1;
        end
    end

    // restart timer, back to zero on any fault
    always_ff @(posedge clk) begin
        if (!rst_b || state_ff != sfs_pkg::ST_RESTART || fault) begin
            rst_cnt_ff <= 32'h0;
        end else if (rst_cnt_ff < T_RST) begin
            rst_cnt_ff <= rst_cnt_ff + 32'h1;
        end
    end

    // transition bleed length from step size and new level
    assign trans_len = vtrans.small_step ? (vtrans.above_13v ? T_SHI : T_SLO)
        : (vtrans.above_13v ? T_BHI : T_BLO);

    // bleed timer: full discharge events win over transitions
    always_comb begin
        nxt_vbus_bleed_pin = (vbus_bleed_pin_cnt_ff != 32'h0) ? vbus_bleed_pin_cnt_ff - 32'h1 : 32'h0;
        if (detach || hard_reset || (state_ff == sfs_pkg::ST_PROT && !fault)) begin
            nxt_vbus_bleed_pin = T_BLO;
        end else if (vtrans.req && state_ff == sfs_pkg::ST_ON) begin
            nxt_vbus_bleed_pin = trans_len;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vbus_bleed_pin_cnt_ff <= 32'h0;
        end else begin
            vbus_bleed_pin_cnt_ff <= nxt_vbus_bleed_pin;
        end
    end

    // outputs; heavy load discharges itself, so bleed only at light load
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_ff <= 1'b0;
            dsw_ff <= 1'b0;
            bleed_ff <= 1'b0;
        end else begin
            en_ff <= (nxt_state == sfs_pkg::ST_ON);
            dsw_ff <= (nxt_state == sfs_pkg::ST_ON) && (att_cnt_ff >= T_DSW);
            bleed_ff <= fl.light_load && ((nxt_vbus_bleed_pin != 32'h0)
                || nxt_state == sfs_pkg::ST_PROT);
        end
    end
    assign converter_enable_out = en_ff;
    assign data_switch_ctrl = dsw_ff;
    assign vbus_bleed_pin = bleed_ff;
    assign source_pullup_current = (state_ff != sfs_pkg::ST_PROT)
        && (state_ff != sfs_pkg::ST_RESTART);
    assign protection_active = (state_ff == sfs_pkg::ST_PROT);
    assign cdp_mode = 1'b1;

    // cable supply: trim gated, limit flag sticky until the state machine is idle
    assign vconn_enable = trim5a_ff && cable_discover_req && !cable_lim_ff
        && (state_ff == sfs_pkg::ST_ON);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cable_lim_ff <= 1'b0;
        end else if (deb_out[2]) begin
            cable_lim_ff <= 1'b1;
        end else if (state_ff == sfs_pkg::ST_IDLE) begin
            cable_lim_ff <= 1'b0;
        end
    end
    assign cable_limit = cable_lim_ff;

    // power selection and scaling
    assign sel = {power_select_msb, power_select_lsb};
    assign cfg_pct = (sel == 2'h3) ? `PCT_100 : (sel == 2'h2) ? `PCT_75
        : (sel == 2'h1) ? `PCT_50 : `PCT_25;
    assign scale_pct = (bat_low && fl.ntc_warn) ? `SCALE_MIN
        : (bat_low || fl.ntc_warn) ? `SCALE_DEF : `PCT_100;
    assign adv_prod = 14'(cfg_pct) * 14'(scale_pct);
    assign adv_div = adv_prod / 14'h64;

    // a new advertisement or pin change sends fresh capabilities
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_ff <= 2'h0;
            adv_ff <= `PCT_25;
            caps_ff <= 1'b0;
        end else begin
            sel_ff <= sel;
            adv_ff <= adv_div[6:0];
            caps_ff <= (state_ff == sfs_pkg::ST_ON) && ((sel != sel_ff)
                || (adv_div[6:0] != adv_ff) || (deb_out[2] && !cable_lim_ff));
        end
    end
    assign advertised_power = adv_ff;
    assign caps_update = caps_ff;

    // register port: control write, status read one cycle later
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            trim5a_ff <= `CTRL_RST;
            rdata_ff <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL) begin
                trim5a_ff <= reg_wdata[`CTRL_TRIM5A];
            end
            if (!reg_rd) begin
                rdata_ff <= 32'h0;
            end else if (reg_addr == `REG_CTRL) begin
                rdata_ff <= {31'h0, trim5a_ff};
            end else if (reg_addr == `REG_STATUS) begin
                rdata_ff <= {16'h0, 1'b0, adv_ff, fl.ntc_warn, bat_low,
                    cable_lim_ff, protection_active, 1'b0, state_ff};
            end else begin
                rdata_ff <= 32'h0;
            end
        end
    end
    assign reg_rdata = rdata_ff;

    // checks
    chk_bleed_light: assert property (@(posedge clk) disable iff (!rst_b)
        vbus_bleed_pin |-> $past(fl.light_load))
        else $error("bleed at heavy load");
    chk_fault_off: assert property (@(posedge clk) disable iff (!rst_b)
        (fault && state_ff == sfs_pkg::ST_ON) |=> !converter_enable_out && protection_active)
        else $error("converter on after fault");
    chk_pullup_prot: assert property (@(posedge clk) disable iff (!rst_b)
        fault |=> !source_pullup_current)
        else $error("pull-up on in protection");
    chk_en_delay: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(converter_enable_out) |-> $past(att_cnt_ff) >= T_EN)
        else $error("converter enabled early");
    chk_dsw_delay: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(data_switch_ctrl) |-> converter_enable_out && $past(att_cnt_ff) >= T_DSW)
        else $error("data switch early");
    chk_detach_low: assert property (@(posedge clk) disable iff (!rst_b)
        detach |=> !data_switch_ctrl && !converter_enable_out && vbus_bleed_pin_cnt_ff == T_BLO)
        else $error("detach not handled");
    chk_restart_wait: assert property (@(posedge clk) disable iff (!rst_b)
        (state_ff == sfs_pkg::ST_RESTART && nxt_state == sfs_pkg::ST_IDLE)
        |-> rst_cnt_ff >= T_RST)
        else $error("restart too soon");
    chk_both_scale: assert property (@(posedge clk) disable iff (!rst_b)
        (bat_low && fl.ntc_warn) |=> advertised_power == 7'(($past(cfg_pct) * 25) / 100))
        else $error("wrong scaling");
    chk_sel_caps: assert property (@(posedge clk) disable iff (!rst_b)
        (state_ff == sfs_pkg::ST_ON && sel != sel_ff) |=> caps_update)
        else $error("no capabilities after pin change");
    chk_cable_off: assert property (@(posedge clk) disable iff (!rst_b)
        deb_out[2] |=> cable_limit && !vconn_enable)
        else $error("cable supply on after limit");
    cov_power_on: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(data_switch_ctrl));
    cov_protect: cover property (@(posedge clk) disable iff (!rst_b)
        $rose(protection_active));
    cov_restart: cover property (@(posedge clk) disable iff (!rst_b)
        state_ff == sfs_pkg::ST_RESTART ##1 state_ff == sfs_pkg::ST_IDLE);
endmodule

/* File: test/sink_conv_model.sv */
// sink, cable and converter model facing the supervisor's power pins
module sink_conv_model (
    // clock
    input wire logic clk,
    // from the supervisor
    input wire logic converter_enable_out,
    input wire logic vbus_bleed_pin,
    input wire logic source_pullup_current,
    // scenario controls
    input wire logic plug,
    input wire logic heavy,
    input wire logic stuck,
    // to the supervisor
    output logic cc_attached,
    output logic vbus_present,
    output logic light_load
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] vlev_ff = 4'h0;
    // the sink only sees an attach while the source offers its pull-ups
    always_ff @(posedge clk) begin
        cc_attached <= plug && source_pullup_current;
    end
    // converter charges vbus; bleed or heavy load drains it, else it holds
    always_ff @(posedge clk) begin
        if (converter_enable_out) vlev_ff <= 4'hF;
        else if (vbus_bleed_pin || heavy) vlev_ff <= (vlev_ff > 4'h2) ? vlev_ff - 4'h2 : 4'h0;
    end
    // stuck models a foreign supply already on the connector
    assign vbus_present = stuck || (vlev_ff > 4'h2);
    assign light_load = !heavy;
endmodule

/* File: test/source_fault_supervisor_bench.sv */
// self-checking bench for the source fault supervisor
module source_fault_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned T_EN = 20, T_DSW = 60, T_RST = 30;
    localparam int unsigned TB [4] = '{5, 7, 9, 11};
    localparam logic [6:0] PCT [4] = '{7'h64, 7'h4B, 7'h32, 7'h19};
    localparam int FB [7] = '{13, 12, 10, 9, 8, 7, 6};
    logic clk = 1'h0, rst_b = 1'h0;
    logic [13:2] flt = '0;
    logic bsf = 1'h0, hrst = 1'h0, fixc = 1'h0, cdr = 1'h0, pmsb = 1'h0, plsb = 1'h0;
    logic plug = 1'h0, heavy = 1'h0, stuck = 1'h0, wr = 1'h0, rd = 1'h0;
    logic [3:0] ra = '0;
    logic [31:0] wd = '0, rdat;
    sfs_pkg::vtrans_t vt = '0;
    sfs_pkg::cmp_flags_t cf;
    logic conv, dsw, bleed, pull, vconn, cdp, capu, clim, prot, cca, vbp, ll;
    logic [6:0] adv, obs;
    int mismatches = 0, num_checks = 0;
    assign cf = sfs_pkg::cmp_flags_t'({flt, ll, vbp});
    assign obs = {cca, capu, prot, pull, bleed, dsw, conv};
    always #4 clk = ~clk;
    source_fault_supervisor #(.T_EN(T_EN), .T_DSW(T_DSW), .T_SHI(TB[0]), .T_SLO(TB[1]),
        .T_BHI(TB[2]), .T_BLO(TB[3]), .T_BAT(4), .T_RST(T_RST), .T_OCP(3), .T_CCO(3),
        .T_VCO(3)) u_source_fault_supervisor (.clk(clk), .rst_b(rst_b), .cmp_flags(cf),
        .battery_sense_float(bsf), .cc_attached(cca), .hard_reset(hrst), .vtrans(vt),
        .fixed_contract(fixc), .cable_discover_req(cdr), .power_select_msb(pmsb),
        .power_select_lsb(plsb), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdat), .converter_enable_out(conv), .data_switch_ctrl(dsw),
        .vbus_bleed_pin(bleed), .source_pullup_current(pull), .vconn_enable(vconn),
        .cdp_mode(cdp), .advertised_power(adv), .caps_update(capu), .cable_limit(clim),
        .protection_active(prot));
    sink_conv_model u_sink_conv_model (.clk(clk), .converter_enable_out(conv),
        .vbus_bleed_pin(bleed), .source_pullup_current(pull), .plug(plug), .heavy(heavy),
        .stuck(stuck), .cc_attached(cca), .vbus_present(vbp), .light_load(ll));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait on one observed output; running out ends the run
    task automatic wt(input int b, input logic v, input int lim);
        int k;
        k = 0;
        while (obs[b] !== v && k < lim) begin
            cyc(1);
            k++;
        end
        if (obs[b] !== v) begin
            chk("wait bound", 32'(b), 32'hFF);
            test_done();
        end
    endtask
    task automatic rwr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rrd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        ra <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        d = rdat;
    endtask
    task automatic bleed_len(output int n);
        wt(2, 1'h1, 6);
        n = 0;
        while (bleed === 1'h1 && n < 300) begin
            cyc(1);
            n++;
        end
    endtask
    // plug in and wait for the data switch; optionally time both outputs
    task automatic go_on(input logic timed);
        int k, ce;
        @(posedge clk) plug <= 1'h1;
        wt(6, 1'h1, 200);
        k = 0;
        ce = 0;
        while (dsw !== 1'h1 && k < 400) begin
            cyc(1);
            k++;
            if (conv === 1'h1 && ce == 0) ce = k;
        end
        if (timed) begin
            chk("enable delay", 32'(ce >= T_EN && ce <= T_EN + 4), 1);
            chk("switch delay", 32'(k >= T_DSW && k <= T_DSW + 4), 1);
        end
        wt(1, 1'h1, 1);
    endtask
    // main sequence
    initial begin
        logic [31:0] d;
        int n;
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        cyc(30);
        chk("conv idle", conv, 0);
        chk("dsw idle", dsw, 0);
        chk("pull", pull, 1);
        chk("cdp", cdp, 1);
        chk("vconn", vconn, 0);
        $display("test reset done");
        go_on(1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) {pmsb, plsb} <= 2'(3 - i);
            wt(5, 1'h1, 4);
            cyc(2);
            chk("cfg power", adv, PCT[i]);
        end
        @(posedge clk) {pmsb, plsb} <= 2'h3;
        @(posedge clk) flt[4] <= 1'h1;
        cyc(12);
        chk("divider mode", adv, 7'h64);
        @(posedge clk) bsf <= 1'h1;
        cyc(3);
        chk("debounce", adv, 7'h64);
        cyc(10);
        chk("bat low", adv, 7'h4B);
        @(posedge clk) flt[2] <= 1'h1;
        cyc(6);
        chk("both low", adv, 7'h19);
        @(posedge clk) flt[4] <= 1'h0;
        cyc(6);
        chk("ntc only", adv, 7'h4B);
        @(posedge clk) {pmsb, plsb} <= 2'h1;
        cyc(4);
        chk("ntc half", adv, 7'h25);
        @(posedge clk) flt[2] <= 1'h0;
        {pmsb, plsb} <= 2'h3;
        cyc(6);
        chk("recovered", adv, 7'h64);
        $display("test power done");
        @(posedge clk) heavy <= 1'h1;
        @(posedge clk) vt <= '{1'h1, 1'h0, 1'h0};
        @(posedge clk) vt <= '0;
        cyc(4);
        chk("heavy load", bleed, 0);
        cyc(12);
        @(posedge clk) heavy <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) vt <= '{1'h1, !i[1], !i[0]};
            @(posedge clk) vt <= '0;
            bleed_len(n);
            chk("bleed len", 32'(n >= TB[i] - 1 && n <= TB[i] + 2), 1);
            chk("conv kept", conv, 1);
        end
        @(posedge clk) hrst <= 1'h1;
        @(posedge clk) hrst <= 1'h0;
        bleed_len(n);
        chk("hard reset bleed", 32'(n >= TB[3] - 1 && n <= TB[3] + 2), 1);
        go_on(0);
        $display("test bleed done");
        @(posedge clk) cdr <= 1'h1;
        cyc(3);
        chk("vconn untrimmed", vconn, 0);
        rwr(4'h0, 32'h1);
        rrd(4'h0, d);
        chk("ctrl", d, 32'h1);
        cyc(2);
        chk("vconn on", vconn, 1);
        @(posedge clk) flt[5] <= 1'h1;
        cyc(10);
        chk("vconn off", vconn, 0);
        chk("cable limit", clim, 1);
        chk("no fault", prot, 0);
        rrd(4'h4, d);
        chk("status", d, {17'h0, 7'h64, 8'h22});
        rrd(4'h8, d);
        chk("unmapped", d, 32'h0);
        @(posedge clk) flt[5] <= 1'h0;
        $display("test cable done");
        @(posedge clk) flt[11] <= 1'h1;
        cyc(10);
        chk("ocp unarmed", prot, 0);
        @(posedge clk) fixc <= 1'h1;
        wt(4, 1'h1, 10);
        cyc(4);
        chk("ocp held", prot, 1);
        @(posedge clk) flt[11] <= 1'h0;
        wt(3, 1'h1, T_RST + 20);
        go_on(0);
        @(posedge clk) flt[7] <= 1'h1;
        @(posedge clk) flt[7] <= 1'h0;
        cyc(10);
        chk("cc glitch", prot, 0);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk) flt[FB[i]] <= 1'h1;
            wt(4, 1'h1, 10);
            cyc(2);
            chk("conv off", conv, 0);
            chk("dsw off", dsw, 0);
            chk("pull off", pull, 0);
            chk("bleed on", bleed, 1);
            if (i == 0) begin
                @(posedge clk) heavy <= 1'h1;
                cyc(4);
                chk("heavy no bleed", bleed, 0);
                @(posedge clk) heavy <= 1'h0;
                @(posedge clk) flt[13] <= 1'h0;
                cyc(6);
                chk("restarting", prot, 0);
                chk("bleed again", bleed, 1);
                cyc(12);
                @(posedge clk) flt[12] <= 1'h1;
                wt(4, 1'h1, 10);
            end
            @(posedge clk) flt <= '0;
            cyc(20);
            chk("pull held", pull, 0);
            wt(3, 1'h1, 20);
            go_on(0);
        end
        $display("test faults done");
        @(posedge clk) plug <= 1'h0;
        bleed_len(n);
        chk("detach bleed", 32'(n >= TB[3] - 1 && n <= TB[3] + 2), 1);
        chk("conv detach", conv, 0);
        chk("dsw detach", dsw, 0);
        @(posedge clk) stuck <= 1'h1;
        @(posedge clk) plug <= 1'h1;
        cyc(T_EN + 20);
        chk("vbus present", conv, 0);
        @(posedge clk) stuck <= 1'h0;
        wt(0, 1'h1, 8);
        $display("test attach done");
        test_done();
    end
endmodule
